/* File: eeac_array.sv */
// Purpose: Byte storage of the data EEPROM.
// Assumes: One write port, one asynchronous read port.
// Notes:   Contents are not reset, as in a real nonvolatile array.
`timescale 1ns/1ns
module eeac_array
(
	// Clock
	input  wire logic                           clk_sys,
	// Write port
	input  wire logic                           memWe,
	input  wire logic [eeac_pkg::MEM_AW-1:0]    memWaddr,
	input  wire logic [eeac_pkg::REG_DW-1:0]    memWdata,
	// Read port
	input  wire logic [eeac_pkg::MEM_AW-1:0]    memRaddr,
	output logic      [eeac_pkg::REG_DW-1:0]    memRdata
);

	logic [eeac_pkg::REG_DW-1:0] cells [eeac_pkg::MEM_DEPTH];

	// Combinational read so a read completes in one cycle
	assign memRdata = cells[memRaddr];

	// Store one byte per write strobe
	always_ff @(posedge clk_sys)
	begin
		if (memWe)
		begin
			cells[memWaddr] <= memWdata;
		end
	end

endmodule : eeac_array

/* File: eeac_ctrl.sv */
// Purpose: Register-level access controller for a 1024-byte data EEPROM.
// Assumes: Bus strobes are one cycle wide; reset requests are synchronous pulses.
// Notes:   rst_b is the power-on reset; pin and watchdog resets arrive as requests.
//
// Contract
// - 1024 bytes, addresses 000h to 3FFh, reached only through registers.
// - Two top address bits in high register, eight in low; rest reads zero.
// - Each byte write erases then programs, timed by an internal timer.
// - Unlock port stores nothing and always reads zero.
// - Software only sets read and write start; hardware clears them.
// - Write start runs a self-timed cycle and clears when it completes.
// - Read completes in one cycle; refused while memory space select set.
// - Read byte is in the data register for the next cycle.
// - Data register holds until another read, a software write, or a pin or watchdog reset.
// - Writes only with write enable set; enable cleared at power-up.
// - Error flag set when a pin or watchdog reset cuts a write short.
// - Reset clears address and data registers.
// - Write completion sets done flag; software or a pin or watchdog reset clears it.
// - Write start needs enable already set; not both in one write.
// - Control, address and data registers are frozen during a write.
// - Hardware clears write enable only on a pin or watchdog reset.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module eeac_ctrl #(
	parameter int WRITE_CYCLES = eeac_pkg::WRITE_CYCLES
)
(
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst_b,
	// Register bus
	input  wire eeac_pkg::eeac_req_t               busReq,
	output logic      [eeac_pkg::REG_DW-1:0]       regRdata,
	// Reset requests from the rest of the chip
	input  wire logic                              extResetReq,
	input  wire logic                              watchdogResetReq,
	// Program memory row erase
	input  wire logic [eeac_pkg::TBL_W-1:0]        tablePointer,
	output logic                                   rowEraseStart,
	output logic      [eeac_pkg::TBL_W-1:0]        rowEraseAddr,
	// Status
	output logic                                   writeBusy,
	output logic                                   writeDoneFlag
);

	localparam int PHASE_RAW = WRITE_CYCLES / 2;
	localparam int PHASE_CYC = (PHASE_RAW < 1) ? 1 : PHASE_RAW;

	eeac_pkg::eeac_core_t              s_q;
	eeac_pkg::eeac_core_t              s_d;
	logic                              timerLoad;
	logic                              timerAbort;
	logic                              timerDone;
	logic                              memWe;
	logic [eeac_pkg::REG_DW-1:0]       memWdata;
	logic [eeac_pkg::REG_DW-1:0]       memRdata;
	logic                              busy;
	logic                              sysReset;
	logic                              startOk;
	logic                              doneSet;
	logic [eeac_pkg::REG_DW-1:0]       ctrlView;

	eeac_array u_array (
		.clk_sys  (clk_sys),
		.memWe    (memWe),
		.memWaddr (s_q.addr),
		.memWdata (memWdata),
		.memRaddr (s_q.addr),
		.memRdata (memRdata)
	);

	// internal timer sets each phase length
	eeac_timer #(
		.W (eeac_pkg::CNT_W)
	) u_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.load      (timerLoad),
		.loadValue (eeac_pkg::CNT_W'(PHASE_CYC)),
		.abort     (timerAbort),
		.done      (timerDone)
	);

	// Address and data registers are frozen for the whole cycle
	assign busy     = (s_q.st != eeac_pkg::ST_IDLE);
	assign sysReset = extResetReq || watchdogResetReq;

	// control view with bit 5 reading zero
	assign ctrlView = {s_q.ctrl.memSel, s_q.ctrl.cfgSel, 1'b0, s_q.ctrl.rowEraseArm,
		s_q.ctrl.write_error_flag, s_q.ctrl.write_unlock_enable, s_q.ctrl.wrStart, s_q.ctrl.rdStart};

	// Outputs straight from state flops
	assign regRdata      = s_q.rdata;
	assign rowEraseStart = s_q.rowStart;
	assign rowEraseAddr  = s_q.rowAddr;
	assign writeBusy     = s_q.ctrl.wrStart;
	assign writeDoneFlag = s_q.doneFlag;

	// Next state: cycle sequencing, bus writes, bus reads, reset requests
	always_comb
	begin
		s_d          = s_q;
		s_d.rowStart = 1'b0;
		s_d.rdata    = eeac_pkg::ZERO_BYTE;
		timerLoad    = 1'b0;
		timerAbort   = 1'b0;
		memWe        = 1'b0;
		memWdata     = eeac_pkg::ERASED_BYTE;
		doneSet      = 1'b0;
		startOk      = 1'b0;
		s_d.ctrl.rdStart = 1'b0;

		// Self-timed cycle sequencing
		unique case (s_q.st)
			eeac_pkg::ST_IDLE:
			begin
			end
			eeac_pkg::ST_ERASE:
			begin
				// erase phase ends with the cell blank
				if (timerDone)
				begin
					memWe     = 1'b1;
					memWdata  = eeac_pkg::ERASED_BYTE;
					timerLoad = 1'b1;
					s_d.st    = eeac_pkg::ST_PROG;
				end
			end
			eeac_pkg::ST_PROG:
			begin
				// program phase stores byte, write start clears
				if (timerDone)
				begin
					memWe            = 1'b1;
					memWdata         = s_q.data;
					s_d.ctrl.wrStart = 1'b0;
					doneSet          = 1'b1;
					s_d.st           = eeac_pkg::ST_IDLE;
				end
			end
			eeac_pkg::ST_ROW:
			begin
				if (timerDone)
				begin
					s_d.ctrl.wrStart     = 1'b0;
					s_d.ctrl.rowEraseArm = 1'b0;
					doneSet              = 1'b1;
					s_d.st               = eeac_pkg::ST_IDLE;
				end
			end
			default:
			begin
				s_d.st = eeac_pkg::ST_IDLE;
			end
		endcase

		// Register reads; answer stands the next cycle only
		if (busReq.rd)
		begin
			unique case (busReq.addr)
				eeac_pkg::CTRL_OFS:
					s_d.rdata = ctrlView;
				eeac_pkg::UNLOCK_OFS:
					s_d.rdata = eeac_pkg::ZERO_BYTE;
				eeac_pkg::DATA_OFS:
					s_d.rdata = s_q.data;
				eeac_pkg::ADRL_OFS:
					s_d.rdata = s_q.addr[7:0];
				eeac_pkg::ADRH_OFS:
					s_d.rdata = {6'h00, s_q.addr[9:8]};
				eeac_pkg::FLAG_OFS:
					s_d.rdata = {3'h0, s_q.doneFlag, 4'h0};
				default:
					s_d.rdata = eeac_pkg::ZERO_BYTE;
			endcase
		end

		// Register writes
		if (busReq.wr)
		begin
			// any other write breaks the unlock sequence
			s_d.ul = eeac_pkg::UL_NONE;
			if (busReq.addr == eeac_pkg::UNLOCK_OFS)
			begin
				if (busReq.wdata == eeac_pkg::UNLOCK_KEY1)
				begin
					s_d.ul = eeac_pkg::UL_KEY1;
				end
				else if (busReq.wdata == eeac_pkg::UNLOCK_KEY2 &&
					s_q.ul == eeac_pkg::UL_KEY1)
				begin
					s_d.ul = eeac_pkg::UL_KEY2;
				end
			end

			unique case (busReq.addr)
				eeac_pkg::CTRL_OFS:
				begin
					if (!busy)
					begin
						s_d.ctrl.memSel      = busReq.wdata[eeac_pkg::MEMSEL_BIT];
						s_d.ctrl.cfgSel      = busReq.wdata[eeac_pkg::CFGSEL_BIT];
						s_d.ctrl.rowEraseArm = busReq.wdata[eeac_pkg::FREE_BIT];
						s_d.ctrl.write_error_flag       = busReq.wdata[eeac_pkg::ERROR_BIT];
						s_d.ctrl.write_unlock_enable        = busReq.wdata[eeac_pkg::WEN_BIT];
						// enable must already be set and unlock complete
						startOk = busReq.wdata[eeac_pkg::WR_BIT] && s_q.ctrl.write_unlock_enable &&
							(s_q.ul == eeac_pkg::UL_KEY2) &&
							(busReq.wdata[eeac_pkg::FREE_BIT] ||
							(!busReq.wdata[eeac_pkg::MEMSEL_BIT] &&
							!busReq.wdata[eeac_pkg::CFGSEL_BIT]));
						// start bits only set here, never cleared
						if (startOk)
						begin
							s_d.ctrl.wrStart = 1'b1;
							timerLoad        = 1'b1;
							// armed row erase replaces the byte write
							if (busReq.wdata[eeac_pkg::FREE_BIT])
							begin
								s_d.st       = eeac_pkg::ST_ROW;
								s_d.rowStart = 1'b1;
								s_d.rowAddr  = tablePointer;
							end
							else
							begin
								s_d.st = eeac_pkg::ST_ERASE;
							end
						end
						// read refused with memory space select set
						else if (busReq.wdata[eeac_pkg::RD_BIT] &&
							!busReq.wdata[eeac_pkg::MEMSEL_BIT])
						begin
							s_d.ctrl.rdStart = 1'b1;
							// byte lands in data register at once
							s_d.data         = memRdata;
						end
					end
				end
				eeac_pkg::DATA_OFS:
				begin
					if (!busy && !s_q.ctrl.rdStart)
					begin
						// software write replaces the held byte
						s_d.data = busReq.wdata;
					end
				end
				eeac_pkg::ADRL_OFS:
				begin
					if (!busy && !s_q.ctrl.rdStart)
					begin
						s_d.addr[7:0] = busReq.wdata;
					end
				end
				eeac_pkg::ADRH_OFS:
				begin
					// only two address bits are stored
					if (!busy && !s_q.ctrl.rdStart)
					begin
						s_d.addr[9:8] = busReq.wdata[1:0];
					end
				end
				eeac_pkg::FLAG_OFS:
				begin
					s_d.doneFlag = busReq.wdata[eeac_pkg::DONE_BIT];
				end
				default:
				begin
				end
			endcase
		end

		// completion sets done flag, winning over a software clear
		if (doneSet)
		begin
			s_d.doneFlag = 1'b1;
		end

		// Pin or watchdog reset: abort and clear, keep the space selects
		if (sysReset)
		begin
			// cut-short write leaves the error flag set
			if (busy)
			begin
				s_d.ctrl.write_error_flag = 1'b1;
			end
			s_d.addr             = eeac_pkg::ADDR_RST;
			s_d.data             = eeac_pkg::DATA_RST;
			s_d.ctrl.rowEraseArm = 1'b0;
			s_d.ctrl.write_unlock_enable        = 1'b0;
			s_d.ctrl.wrStart     = 1'b0;
			s_d.ctrl.rdStart     = 1'b0;
			s_d.doneFlag         = 1'b0;
			s_d.ul               = eeac_pkg::UL_NONE;
			s_d.st               = eeac_pkg::ST_IDLE;
			s_d.rowStart         = 1'b0;
			memWe                = 1'b0;
			timerLoad            = 1'b0;
			timerAbort           = 1'b1;
		end
	end

	// State register; power-on clears everything
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q      <= '0;
			s_q.st   <= eeac_pkg::ST_IDLE;
			s_q.ul   <= eeac_pkg::UL_NONE;
			s_q.addr <= eeac_pkg::ADDR_RST;
			s_q.data <= eeac_pkg::DATA_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : eeac_ctrl

/* File: eeac_ctrl_chk.sv */
// Purpose: Port-level checks for the EEPROM access controller.
// Assumes: One clock domain; sees only the top module ports.
// Notes:   Bound to eeac_ctrl below the module.
`timescale 1ns/1ns
module eeac_ctrl_chk #(
	parameter int WRITE_CYCLES = 8
)
(
	// Clock and reset
	input wire logic                         clk_sys,
	input wire logic                         rst_b,
	// Bus and requests
	input wire eeac_pkg::eeac_req_t          busReq,
	input wire logic [eeac_pkg::REG_DW-1:0]  regRdata,
	input wire logic                         extResetReq,
	input wire logic                         watchdogResetReq,
	input wire logic [eeac_pkg::TBL_W-1:0]   tablePointer,
	// Status
	input wire logic                         rowEraseStart,
	input wire logic [eeac_pkg::TBL_W-1:0]   rowEraseAddr,
	input wire logic                         writeBusy,
	input wire logic                         writeDoneFlag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Any reset request, and how long a cycle has run
	logic        anyRst;
	logic [31:0] busyCnt_q;
	assign anyRst = extResetReq | watchdogResetReq;
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			busyCnt_q <= 32'h0000_0000;
		else
			busyCnt_q <= writeBusy ? busyCnt_q + 32'h0000_0001 : 32'h0000_0000;

	rdata_idle_a: assert property (!busReq.rd |=> regRdata == 8'h00)
		else $error("read data not zero outside answer");
	unlock_zero_a: assert property (busReq.rd && busReq.addr == eeac_pkg::UNLOCK_OFS |=> regRdata == 8'h00)
		else $error("unlock port read not zero");
	adrh_upper_zero_a: assert property (busReq.rd && busReq.addr == eeac_pkg::ADRH_OFS |=> regRdata[7:2] == 6'h00)
		else $error("address high upper bits not zero");
	ctrl_gap_zero_a: assert property (busReq.rd && busReq.addr == eeac_pkg::CTRL_OFS |=> !regRdata[5])
		else $error("control bit 5 not zero");
	done_on_finish_a: assert property ($fell(writeBusy) && !$past(anyRst) |-> writeDoneFlag)
		else $error("done flag missing at completion");
	done_sticky_a: assert property (writeDoneFlag && !anyRst && !(busReq.wr && busReq.addr == eeac_pkg::FLAG_OFS) |=> writeDoneFlag)
		else $error("done flag cleared without software");
	busy_bound_a: assert property (busyCnt_q <= 32'(WRITE_CYCLES) + 32'h0000_0004)
		else $error("self-timed cycle too long");
	row_capture_a: assert property (rowEraseStart |-> writeBusy && rowEraseAddr == $past(tablePointer) ##1 !rowEraseStart)
		else $error("row erase start or address wrong");
	abort_clear_a: assert property (anyRst |=> !writeBusy && !writeDoneFlag)
		else $error("reset request did not abort");

	// Main scenarios reached
	row_c: cover property (rowEraseStart);
	finish_c: cover property ($fell(writeBusy));
	abort_c: cover property (anyRst && writeBusy);
endmodule : eeac_ctrl_chk

bind eeac_ctrl eeac_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) uChk (
	.clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq), .regRdata(regRdata),
	.extResetReq(extResetReq), .watchdogResetReq(watchdogResetReq),
	.tablePointer(tablePointer), .rowEraseStart(rowEraseStart),
	.rowEraseAddr(rowEraseAddr), .writeBusy(writeBusy), .writeDoneFlag(writeDoneFlag));

/* File: eeac_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the EEPROM access controller.
// Assumes: WRITE_CYCLES of 8 keeps each self-timed cycle short.
// Notes:   Drives the register bus directly; no partner model.
`timescale 1ns/1ns
module eeac_ctrl_tb_top;
	localparam int          WC = 8;
	localparam logic [11:0] CT = eeac_pkg::CTRL_OFS;
	localparam logic [11:0] UL = eeac_pkg::UNLOCK_OFS;
	localparam logic [11:0] DT = eeac_pkg::DATA_OFS;
	localparam logic [11:0] AL = eeac_pkg::ADRL_OFS;
	localparam logic [11:0] AH = eeac_pkg::ADRH_OFS;
	localparam logic [11:0] FL = eeac_pkg::FLAG_OFS;
	logic                clk_sys;
	logic                rst_b;
	eeac_pkg::eeac_req_t busReq;
	logic [7:0]          regRdata;
	logic                extResetReq;
	logic                watchdogResetReq;
	logic [21:0]         tablePointer;
	logic                rowEraseStart;
	logic [21:0]         rowEraseAddr;
	logic                writeBusy;
	logic                writeDoneFlag;
	int                  err_total;
	int                  cmp_count;

	eeac_ctrl #(.WRITE_CYCLES(WC)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq), .regRdata(regRdata),
		.extResetReq(extResetReq), .watchdogResetReq(watchdogResetReq),
		.tablePointer(tablePointer), .rowEraseStart(rowEraseStart),
		.rowEraseAddr(rowEraseAddr), .writeBusy(writeBusy), .writeDoneFlag(writeDoneFlag));

	// 100 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Value compare
	task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Verdict and end of run
	task automatic report_and_stop();
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// One-cycle write; returns just after the sampling edge
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		busReq.wr <= 1'b0;
		#1;
	endtask : w

	// Two writes back to back; the strobe stays high between them
	task automatic w2(input logic [11:0] a1, input logic [7:0] d1,
		input logic [11:0] a2, input logic [7:0] d2);
		@(posedge clk_sys);
		busReq <= '{addr: a1, wdata: d1, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		busReq <= '{addr: a2, wdata: d2, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		busReq.wr <= 1'b0;
		#1;
	endtask : w2

	// One-cycle read; answer stands only in the next cycle
	task automatic r(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		busReq.rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), 22'(e), 22'(regRdata));
	endtask : r

	// Unlock keys, then a full byte write
	task automatic keys();
		w(UL, eeac_pkg::UNLOCK_KEY1);
		w(UL, eeac_pkg::UNLOCK_KEY2);
	endtask : keys
	task automatic eeWrite(input logic [7:0] d);
		w(DT, d);
		w(CT, 8'h04);
		keys();
		w(CT, 8'h06);
	endtask : eeWrite

	// Bounded wait for the cycle to end
	task automatic waitIdle();
		int n;
		n = 0;
		while (writeBusy !== 1'b0 && n < 40)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (writeBusy !== 1'b0)
		begin
			chk("writeBusy wait", 22'h00_0000, 22'(writeBusy));
			report_and_stop();
		end
	endtask : waitIdle

	// Pulse a pin or watchdog reset request
	task automatic rq(input bit k);
		@(posedge clk_sys);
		if (k)
			watchdogResetReq <= 1'b1;
		else
			extResetReq <= 1'b1;
		@(posedge clk_sys);
		watchdogResetReq <= 1'b0;
		extResetReq <= 1'b0;
		#1;
	endtask : rq

	// Main sequence
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		busReq = '0;
		extResetReq = 1'b0;
		watchdogResetReq = 1'b0;
		tablePointer = 22'h12_3456;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		r(CT, 8'h00);
		r(DT, 8'h00);
		r(UL, 8'h00);
		r(12'h0123, 8'h00);
		w(AH, 8'hff);
		r(AH, 8'h03);
		w(AL, 8'h5a);
		r(AL, 8'h5a);
		// Write, then try to disturb it while it runs
		eeWrite(8'hc3);
		chk("writeBusy", 22'h00_0001, 22'(writeBusy));
		w(DT, 8'h11);
		w(CT, 8'h00);
		r(CT, 8'h06);
		r(DT, 8'hc3);
		waitIdle();
		chk("writeDoneFlag", 22'h00_0001, 22'(writeDoneFlag));
		r(CT, 8'h04);
		r(FL, 8'h10);
		// Read back through a fresh data register
		w(DT, 8'h00);
		r(DT, 8'h00);
		w(CT, 8'h01);
		r(DT, 8'hc3);
		r(CT, 8'h00);
		// Data and address writes right behind a read start are dropped
		w2(CT, 8'h01, DT, 8'h55);
		r(DT, 8'hc3);
		w2(CT, 8'h01, AL, 8'h00);
		r(AL, 8'h5a);
		// Read refused while memory space select is set; bit 5 never stored
		w(DT, 8'h77);
		w(CT, 8'ha1);
		r(DT, 8'h77);
		r(CT, 8'h80);
		// Write start without keys, then with enable in the same write
		w(CT, 8'h04);
		w(CT, 8'h06);
		chk("writeBusy", 22'h00_0000, 22'(writeBusy));
		w(CT, 8'h00);
		keys();
		w(CT, 8'h06);
		chk("writeBusy", 22'h00_0000, 22'(writeBusy));
		r(CT, 8'h04);
		w(FL, 8'h00);
		r(FL, 8'h00);
		// Pin and watchdog resets cut a write short
		for (int k = 0; k < 2; k++)
		begin
			w(AH, 8'h01);
			w(AL, 8'h23);
			eeWrite(8'h99);
			repeat (2) @(posedge clk_sys);
			rq(k[0]);
			chk("writeBusy", 22'h00_0000, 22'(writeBusy));
			r(CT, 8'h08);
			r(AL, 8'h00);
			r(AH, 8'h00);
			r(DT, 8'h00);
			chk("writeDoneFlag", 22'h00_0000, 22'(writeDoneFlag));
		end
		// Armed row erase takes the table pointer
		w(CT, 8'h04);
		keys();
		w(CT, 8'h16);
		chk("rowEraseStart", 22'h00_0001, 22'(rowEraseStart));
		chk("rowEraseAddr", tablePointer, rowEraseAddr);
		waitIdle();
		r(CT, 8'h04);
		chk("writeDoneFlag", 22'h00_0001, 22'(writeDoneFlag));
		report_and_stop();
	end
endmodule : eeac_ctrl_tb_top

/* File: eeac_pkg.sv */
// Purpose: Shared constants and types for the data EEPROM access controller.
// Assumes: 100 MHz core clock; 12-bit register address space, 8-bit registers.
// Notes:   Register offsets, control bit positions and reset values live here.
package eeac_pkg;

	// Bus and storage geometry
	localparam int REG_AW    = 12;
	localparam int REG_DW    = 8;
	localparam int MEM_DEPTH = 1024;
	localparam int MEM_AW    = 10;
	localparam int TBL_W     = 22;

	// Register offsets
	localparam logic [REG_AW-1:0] CTRL_OFS   = 12'h0fa6;
	localparam logic [REG_AW-1:0] UNLOCK_OFS = 12'h0fa7;
	localparam logic [REG_AW-1:0] DATA_OFS   = 12'h0fa8;
	localparam logic [REG_AW-1:0] ADRL_OFS   = 12'h0fa9;
	localparam logic [REG_AW-1:0] ADRH_OFS   = 12'h0faa;
	localparam logic [REG_AW-1:0] FLAG_OFS   = 12'h0fab;

	// Control register bit positions
	localparam int MEMSEL_BIT = 7;
	localparam int CFGSEL_BIT = 6;
	localparam int FREE_BIT   = 4;
	localparam int ERROR_BIT  = 3;
	localparam int WEN_BIT    = 2;
	localparam int WR_BIT     = 1;
	localparam int RD_BIT     = 0;
	// Write-done flag position in the peripheral flag register
	localparam int DONE_BIT   = 4;

	// Unlock keys and the erased byte value
	localparam logic [REG_DW-1:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [REG_DW-1:0] UNLOCK_KEY2 = 8'haa;
	localparam logic [REG_DW-1:0] ERASED_BYTE = 8'hff;
	localparam logic [REG_DW-1:0] ZERO_BYTE   = 8'h00;

	// Reset values
	localparam logic [MEM_AW-1:0] ADDR_RST = 10'h000;
	localparam logic [REG_DW-1:0] DATA_RST = 8'h00;

	// Self-timed write duration
	localparam int CLK_MHZ       = 100;
	localparam int WRITE_TIME_US = 1000;
	localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
	localparam int CNT_W         = 20;

	// Register bus request
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [REG_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} eeac_req_t;

	// Controller activity, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ERASE = 4'b0010,
		ST_PROG  = 4'b0100,
		ST_ROW   = 4'b1000
	} eeac_state_t;

	// Unlock sequence progress, one-hot
	typedef enum logic [2:0] {
		UL_NONE = 3'b001,
		UL_KEY1 = 3'b010,
		UL_KEY2 = 3'b100
	} eeac_unlock_t;

	// Control register contents
	typedef struct packed {
		logic memSel;
		logic cfgSel;
		logic rowEraseArm;
		logic write_error_flag;
		logic write_unlock_enable;
		logic wrStart;
		logic rdStart;
	} eeac_ctrl_t;

	// Whole controller state
	typedef struct packed {
		eeac_state_t       st;
		eeac_unlock_t      ul;
		eeac_ctrl_t        ctrl;
		logic [MEM_AW-1:0] addr;
		logic [REG_DW-1:0] data;
		logic              doneFlag;
		logic [REG_DW-1:0] rdata;
		logic              rowStart;
		logic [TBL_W-1:0]  rowAddr;
	} eeac_core_t;

endpackage : eeac_pkg

/* File: eeac_timer.sv */
// Purpose: Down counter that times one phase of a self-timed cycle.
// Assumes: loadValue is at least one.
// Notes:   done pulses in the last counted cycle; abort stops it silently.
`timescale 1ns/1ns
module eeac_timer #(
	parameter int W = 20
)
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] loadValue,
	input  wire logic         abort,
	// Status
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
	} eeac_tmr_t;

	eeac_tmr_t tmr_q;
	eeac_tmr_t tmr_d;

	// Done while the last cycle of the phase runs
	assign done = tmr_q.run && (tmr_q.cnt == W'(1));

	// Next count
	always_comb
	begin
		tmr_d = tmr_q;
		if (abort)
		begin
			tmr_d.run = 1'b0;
			tmr_d.cnt = '0;
		end
		else if (load)
		begin
			tmr_d.run = 1'b1;
			tmr_d.cnt = loadValue;
		end
		else if (tmr_q.run)
		begin
			tmr_d.cnt = tmr_q.cnt - W'(1);
			tmr_d.run = (tmr_q.cnt != W'(1));
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tmr_q <= '0;
		end
		else
		begin
			tmr_q <= tmr_d;
		end
	end

endmodule : eeac_timer
